// file: core/fcm_ctrl.sv
// flash program and erase control: mode register, error flag, erase block select
`timescale 1ns/1ps
`default_nettype none

module fcm_ctrl (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic hw_write_pin_i,
	input wire logic flash_en_i,
	input wire logic hw_standby_i,
	input wire logic sw_standby_i,
	input wire logic dog_timer_rst_i,
	input wire logic array_read_i,
	input wire logic overlay_read_i,
	input wire logic exc_start_i,
	input wire logic exc_exempt_i,
	input wire logic sleep_exec_i,
	input wire logic bus_release_i,
	output logic write_active_o,
	output logic wash_active_o,
	output logic write_verify_o,
	output logic wash_verify_o,
	output logic [7:0] block_en_o,
	output logic protect_o,
	output logic [1:0] mode_o
);

	// =========================================================
	// state
	fcm_pkg::fcm_state_t st;
	fcm_pkg::fcm_state_t next_st;

	logic ctrl_wr;
	logic sel_wr;
	logic [6:0] wr_ok;
	logic running;
	logic fault_set;
	logic [7:0] block_next;
	logic gate;

	// current soft gate, qualified by the pin
	assign gate = hw_write_pin_i && st.op_ctrl[fcm_pkg::BIT_SOFT_GATE];

	// program or erase is in progress while a run bit is set
	assign running = st.op_ctrl[fcm_pkg::BIT_WRITE_RUN] || st.op_ctrl[fcm_pkg::BIT_WASH_RUN];

	// =========================================================
	// error event detection
	fcm_fault_detect u_fault (
		.running_i(running),
		.array_read_i(array_read_i),
		.overlay_read_i(overlay_read_i),
		.exc_start_i(exc_start_i),
		.exc_exempt_i(exc_exempt_i),
		.sleep_exec_i(sleep_exec_i),
		.bus_release_i(bus_release_i),
		.fault_set_o(fault_set)
	);

	// =========================================================
	// per block erase enable
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_block
			// only the selected block sees an erase; others stay protected
			assign block_next[gi] = next_st.wash_sel[gi] && next_st.wash_active;
		end
	endgenerate

	// =========================================================
	// write gating per control bit
	always_comb begin
		wr_ok = '0;
		wr_ok[fcm_pkg::BIT_SOFT_GATE] = hw_write_pin_i;
		wr_ok[fcm_pkg::BIT_WASH_ARM] = gate;
		wr_ok[fcm_pkg::BIT_WRITE_ARM] = gate;
		wr_ok[fcm_pkg::BIT_WASH_CHECK] = gate;
		wr_ok[fcm_pkg::BIT_WRITE_CHECK] = gate;
		// run bits need their own setup bit already set
		wr_ok[fcm_pkg::BIT_WASH_RUN] = gate && st.op_ctrl[fcm_pkg::BIT_WASH_ARM];
		wr_ok[fcm_pkg::BIT_WRITE_RUN] = gate && st.op_ctrl[fcm_pkg::BIT_WRITE_ARM];
	end

	// =========================================================
	// next state
	always_comb begin
		next_st = st;
		// a disabled flash ignores every write
		ctrl_wr = wr_i && flash_en_i && (addr_i == fcm_pkg::OFS_OP_CTRL);
		sel_wr = wr_i && flash_en_i && (addr_i == fcm_pkg::OFS_WASH_SEL_LO);

		// control bits: refused bits keep their value, the rest take the data
		if (ctrl_wr) begin
			next_st.op_ctrl = (st.op_ctrl & ~wr_ok) | (wdata_i[6:0] & wr_ok);
		end
		// pin low is hardware protection: nothing soft may stay set
		if (!hw_write_pin_i) begin
			next_st.op_ctrl = fcm_pkg::OP_CTRL_RESET;
		end
		// both standby modes initialise the control register
		if (hw_standby_i || sw_standby_i) begin
			next_st.op_ctrl = fcm_pkg::OP_CTRL_RESET;
		end

		// erase block select follows the soft gate
		if (sel_wr && gate) begin
			next_st.wash_sel = wdata_i;
		end
		if (!gate || hw_standby_i || sw_standby_i) begin
			next_st.wash_sel = fcm_pkg::WASH_SEL_RESET;
		end

		// error flag: apart from pin reset, cleared by watchdog reset or hardware standby only
		if (dog_timer_rst_i || hw_standby_i) begin
			next_st.op_fault = fcm_pkg::OP_FAULT_RESET;
		end
		// a set in the same cycle as a clear wins
		if (fault_set) begin
			next_st.op_fault = 1'h1;
		end

		// mode summary from the new control bits
		if (next_st.op_ctrl[fcm_pkg::BIT_WRITE_RUN] || next_st.op_ctrl[fcm_pkg::BIT_WASH_RUN]) begin
			next_st.mode = fcm_pkg::FCM_RUN;
		end else if (next_st.op_ctrl[fcm_pkg::BIT_WRITE_CHECK]
				|| next_st.op_ctrl[fcm_pkg::BIT_WASH_CHECK]) begin
			next_st.mode = fcm_pkg::FCM_CHECK;
		end else if (next_st.op_ctrl[fcm_pkg::BIT_SOFT_GATE]) begin
			next_st.mode = fcm_pkg::FCM_SETUP;
		end else begin
			next_st.mode = fcm_pkg::FCM_IDLE;
		end

		// array drive: error protection overrides the run bits
		next_st.write_active = next_st.op_ctrl[fcm_pkg::BIT_WRITE_RUN]
			&& !next_st.op_fault && flash_en_i;
		next_st.wash_active = next_st.op_ctrl[fcm_pkg::BIT_WASH_RUN]
			&& !next_st.op_fault && flash_en_i;
		next_st.write_verify = next_st.op_ctrl[fcm_pkg::BIT_WRITE_CHECK] && flash_en_i;
		next_st.wash_verify = next_st.op_ctrl[fcm_pkg::BIT_WASH_CHECK] && flash_en_i;
		next_st.protect = next_st.op_fault;
		next_st.block_en = block_next;

		// read data stands for exactly one cycle after the strobe
		next_st.rdata = fcm_pkg::READ_OFF;
		if (rd_i) begin
			if (!flash_en_i) begin
				next_st.rdata = fcm_pkg::READ_OFF;
			end else if (addr_i == fcm_pkg::OFS_OP_CTRL) begin
				// top bit mirrors the pin, giving 0x80 or 0x00 after init
				next_st.rdata = {hw_write_pin_i, st.op_ctrl};
			end else if (addr_i == fcm_pkg::OFS_FAULT_STAT) begin
				next_st.rdata = {st.op_fault, fcm_pkg::STAT_LOW_ZERO};
			end else if (addr_i == fcm_pkg::OFS_WASH_SEL_LO) begin
				next_st.rdata = st.wash_sel;
			end else begin
				next_st.rdata = fcm_pkg::READ_OFF;
			end
		end
	end

	// =========================================================
	// state register
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st.op_ctrl <= fcm_pkg::OP_CTRL_RESET;
			st.op_fault <= fcm_pkg::OP_FAULT_RESET;
			st.wash_sel <= fcm_pkg::WASH_SEL_RESET;
			st.rdata <= fcm_pkg::READ_OFF;
			st.mode <= fcm_pkg::FCM_IDLE;
			st.write_active <= 1'h0;
			st.wash_active <= 1'h0;
			st.write_verify <= 1'h0;
			st.wash_verify <= 1'h0;
			st.block_en <= 8'h00;
			st.protect <= 1'h0;
		end else begin
			st <= next_st;
		end
	end

	// =========================================================
	// outputs
	assign rdata_o = st.rdata;
	assign write_active_o = st.write_active;
	assign wash_active_o = st.wash_active;
	assign write_verify_o = st.write_verify;
	assign wash_verify_o = st.wash_verify;
	assign block_en_o = st.block_en;
	assign protect_o = st.protect;
	assign mode_o = st.mode;

	// =========================================================
	// checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	top_bit_mirror_a: assert property (
		rd_i && flash_en_i && addr_i == fcm_pkg::OFS_OP_CTRL
		|=> rdata_o[7] == $past(hw_write_pin_i)
	) else $error("control top bit does not follow the pin");

	off_read_zero_a: assert property (
		rd_i && !flash_en_i |=> rdata_o == 8'h00 ##1 (rdata_o == 8'h00 || $past(rd_i))
	) else $error("disabled flash read not zero");

	gate_pin_block_a: assert property (
		!hw_write_pin_i |=> !st.op_ctrl[fcm_pkg::BIT_SOFT_GATE]
	) else $error("soft gate set while pin low");

	write_run_arm_a: assert property (
		$rose(st.op_ctrl[fcm_pkg::BIT_WRITE_RUN])
		|-> $past(st.op_ctrl[fcm_pkg::BIT_WRITE_ARM] && gate && ctrl_wr)
	) else $error("write_run set without arm and gate");

	wash_run_arm_a: assert property (
		$rose(st.op_ctrl[fcm_pkg::BIT_WASH_RUN])
		|-> $past(st.op_ctrl[fcm_pkg::BIT_WASH_ARM] && gate && ctrl_wr)
	) else $error("block_wash_run set without arm and gate");

	fault_sticky_a: assert property (
		st.op_fault && !dog_timer_rst_i && !hw_standby_i |=> st.op_fault
	) else $error("op_fault cleared without a clearing cause");

	fault_blocks_a: assert property (
		st.op_fault |-> !write_active_o && !wash_active_o && block_en_o == 8'h00
	) else $error("array activity while op_fault set");

	read_sets_fault_a: assert property (
		running && array_read_i && !overlay_read_i
		|=> st.op_fault ##1 (st.op_fault || $past(dog_timer_rst_i || hw_standby_i))
	) else $error("array read during run did not set op_fault");

	stat_low_zero_a: assert property (
		rd_i && addr_i == fcm_pkg::OFS_FAULT_STAT |=> rdata_o[6:0] == 7'h00
	) else $error("fault register low bits not zero");

	standby_init_a: assert property (
		sw_standby_i || hw_standby_i |=> st.op_ctrl == 7'h00 && st.wash_sel == 8'h00
	) else $error("standby did not initialise control");

	block_protect_a: assert property (
		(block_en_o & ~st.wash_sel) == 8'h00
	) else $error("unselected block enabled for erase");

	refused_keep_a: assert property (
		ctrl_wr && hw_write_pin_i && !gate && !sw_standby_i && !hw_standby_i
		|=> st.op_ctrl[5:0] == $past(st.op_ctrl[5:0])
	) else $error("gated bits changed without the soft gate");

	exc_sets_fault_a: assert property (
		running && exc_start_i && !exc_exempt_i |=> st.op_fault
	) else $error("exception during run did not set op_fault");

	power_sets_fault_a: assert property (
		running && (sleep_exec_i || bus_release_i) |=> st.op_fault
	) else $error("sleep or bus release during run did not set op_fault");

	soft_gate_pin_a: assert property (
		$rose(st.op_ctrl[fcm_pkg::BIT_SOFT_GATE]) |-> $past(hw_write_pin_i && ctrl_wr)
	) else $error("soft gate set without the pin");

	check_gate_a: assert property (
		$rose(st.op_ctrl[fcm_pkg::BIT_WASH_CHECK] || st.op_ctrl[fcm_pkg::BIT_WRITE_CHECK])
		|-> $past(gate && ctrl_wr)
	) else $error("verify bit set without the soft gate");

	sel_needs_gate_a: assert property (
		!gate |=> st.wash_sel == 8'h00
	) else $error("block select kept without the soft gate");

	drive_needs_run_a: assert property (
		!(write_active_o && !st.op_ctrl[fcm_pkg::BIT_WRITE_RUN])
		&& !(wash_active_o && !st.op_ctrl[fcm_pkg::BIT_WASH_RUN])
	) else $error("array drive without its run bit");

endmodule : fcm_ctrl

`default_nettype wire

// file: core/fcm_pkg.sv
// constants, types and state layout for the flash program and erase control block
//
// Contract
// - Verify modes need soft_write_gate set under hw_write_pin, then write_check or wash_check.
// - Program mode: soft_write_gate with pin high, then write_arm, then write_run.
// - Erase mode: soft_write_gate with pin high, then wash_arm, then block_wash_run.
// - flash_op_ctrl resets on reset and standby; reads 0x80 with pin high, else 0x00.
// - With flash disabled, flash_op_ctrl reads 0x00 and writes are ignored.
// - soft_write_gate writable only with pin high; arm and check bits also need gate.
// - block_wash_run writable only with pin, soft_write_gate and wash_arm all high.
// - write_run writable only with pin, soft_write_gate and write_arm all high.
// - Top control bit is read-only and mirrors the pin; 0 means hardware protected.
// - In single-chip normal mode the pin is held low by the outside.
// - Fault register clears on reset and hardware standby, reads 0 when disabled, low bits zero.
// - op_fault set enters error protection; cleared only by pin reset, watchdog, hardware standby.
// - op_fault sets on array reads during program or erase, overlay RAM reads excluded.
// - op_fault sets at exception start during program or erase, listed exceptions exempt.
// - op_fault sets on sleep, software standby or bus release during program or erase.
// - Each set low block-select bit enables erasing its block; clear bits stay protected.
package fcm_pkg;

	// =========================================================
	// register map
	localparam logic [7:0] OFS_OP_CTRL = 8'h30;
	localparam logic [7:0] OFS_FAULT_STAT = 8'h31;
	localparam logic [7:0] OFS_WASH_SEL_LO = 8'h32;

	// =========================================================
	// flash_op_ctrl bit positions
	localparam int BIT_HW_WRITE = 7;
	localparam int BIT_SOFT_GATE = 6;
	localparam int BIT_WASH_ARM = 5;
	localparam int BIT_WRITE_ARM = 4;
	localparam int BIT_WASH_CHECK = 3;
	localparam int BIT_WRITE_CHECK = 2;
	localparam int BIT_WASH_RUN = 1;
	localparam int BIT_WRITE_RUN = 0;

	// flash_fault_stat bit position
	localparam int BIT_OP_FAULT = 7;

	// =========================================================
	// values after reset and fixed read values
	localparam logic [6:0] OP_CTRL_RESET = 7'h00;
	localparam logic OP_FAULT_RESET = 1'h0;
	localparam logic [7:0] WASH_SEL_RESET = 8'h00;
	localparam logic [7:0] READ_OFF = 8'h00;
	localparam logic [6:0] STAT_LOW_ZERO = 7'h00;

	// =========================================================
	// operating mode, gray coded along idle, setup, run, check
	typedef enum logic [1:0] {
		FCM_IDLE = 2'h0,
		FCM_SETUP = 2'h1,
		FCM_RUN = 2'h3,
		FCM_CHECK = 2'h2
	} fcm_mode_t;

	// =========================================================
	// whole state of the control block
	typedef struct packed {
		logic [6:0] op_ctrl;
		logic op_fault;
		logic [7:0] wash_sel;
		logic [7:0] rdata;
		fcm_mode_t mode;
		logic write_active;
		logic wash_active;
		logic write_verify;
		logic wash_verify;
		logic [7:0] block_en;
		logic protect;
	} fcm_state_t;

endpackage : fcm_pkg

// file: core/fcm_fault_detect.sv
// qualifies illegal activity during program or erase into an error set pulse
`timescale 1ns/1ps
`default_nettype none

module fcm_fault_detect (
	input wire logic running_i,
	input wire logic array_read_i,
	input wire logic overlay_read_i,
	input wire logic exc_start_i,
	input wire logic exc_exempt_i,
	input wire logic sleep_exec_i,
	input wire logic bus_release_i,
	output logic fault_set_o
);

	// =========================================================
	// event qualification
	logic read_hit;
	logic exc_hit;
	logic power_hit;

	// reads served by overlay RAM never touch the array
	assign read_hit = array_read_i && !overlay_read_i;

	// reset, illegal instruction, trap and divide by zero are exempt
	assign exc_hit = exc_start_i && !exc_exempt_i;

	// sleep, software standby entry or handing the bus away
	assign power_hit = sleep_exec_i || bus_release_i;

	assign fault_set_o = running_i && (read_hit || exc_hit || power_hit);

endmodule : fcm_fault_detect

`default_nettype wire

// file: verification/fcm_cpu_model.sv
// partner model: cpu software reaching the flash control registers
`timescale 1ns/1ps
`default_nettype none

module fcm_cpu_model (
	input wire logic clock_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'h0;
		rd_o = 1'h0;
	end

	// ==========
	// bus cycles
	task write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		wr_o <= 1'h1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clock_i);
		wr_o <= 1'h0;
	endtask : write_reg

	task read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		rd_o <= 1'h1;
		addr_o <= a;
		@(posedge clock_i);
		rd_o <= 1'h0;
		#1 d = rdata_i;
	endtask : read_reg

	// ==========
	// mode sequences: gate first, then one new bit per write
	task enter_program;
		write_reg(fcm_pkg::OFS_OP_CTRL, 8'h40);
		write_reg(fcm_pkg::OFS_OP_CTRL, 8'h50);
		write_reg(fcm_pkg::OFS_OP_CTRL, 8'h51);
	endtask : enter_program

	// sel must be one-hot
	task enter_erase(input logic [7:0] sel);
		write_reg(fcm_pkg::OFS_OP_CTRL, 8'h40);
		write_reg(fcm_pkg::OFS_WASH_SEL_LO, sel);
		write_reg(fcm_pkg::OFS_OP_CTRL, 8'h60);
		write_reg(fcm_pkg::OFS_OP_CTRL, 8'h62);
	endtask : enter_erase

	// run bit drops before the gate, so the array is never read mid-run
	task leave_modes;
		write_reg(fcm_pkg::OFS_OP_CTRL, 8'h40);
		write_reg(fcm_pkg::OFS_OP_CTRL, 8'h00);
	endtask : leave_modes
endmodule : fcm_cpu_model
`default_nettype wire

// file: verification/fcm_ctrl_test.sv
// self-checking bench for the flash program and erase control block
`timescale 1ns/1ps
`default_nettype none

module fcm_ctrl_test;
	logic clock_i, sys_rst_i, wr, rd, pin, fen, wact, eact, wver, ever, prot;
	logic [7:0] addr, wdata, rdata, block_en, rv, sel;
	logic [5:0] ev;
	logic [2:0] ctl;
	logic [1:0] mode;
	int n_fail, cmp_count;
	// pin, gate first, write data, read back, mode
	localparam logic [19:0] ROWS [10] = '{
		{1'h1, 1'h0, 8'h40, 8'hC0, 2'h1}, {1'h0, 1'h0, 8'h40, 8'h00, 2'h0},
		{1'h1, 1'h0, 8'h20, 8'h80, 2'h0}, {1'h1, 1'h0, 8'h00, 8'h80, 2'h0},
		{1'h1, 1'h1, 8'h60, 8'hE0, 2'h1}, {1'h1, 1'h1, 8'h50, 8'hD0, 2'h1},
		{1'h1, 1'h1, 8'h48, 8'hC8, 2'h2}, {1'h1, 1'h1, 8'h44, 8'hC4, 2'h2},
		{1'h1, 1'h1, 8'h42, 8'hC0, 2'h1}, {1'h1, 1'h1, 8'h41, 8'hC0, 2'h1}};
	// read, overlay, exception, exempt, sleep, release; fault expected
	localparam logic [6:0] EVTS [6] = '{{6'h20, 1'h1}, {6'h30, 1'h0}, {6'h08, 1'h1},
		{6'h0C, 1'h0}, {6'h02, 1'h1}, {6'h01, 1'h1}};

	fcm_ctrl dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .hw_write_pin_i(pin), .flash_en_i(fen),
		.hw_standby_i(ctl[2]), .sw_standby_i(ctl[1]), .dog_timer_rst_i(ctl[0]),
		.array_read_i(ev[5]), .overlay_read_i(ev[4]), .exc_start_i(ev[3]),
		.exc_exempt_i(ev[2]), .sleep_exec_i(ev[1]), .bus_release_i(ev[0]),
		.write_active_o(wact), .wash_active_o(eact), .write_verify_o(wver),
		.wash_verify_o(ever), .block_en_o(block_en), .protect_o(prot), .mode_o(mode));
	fcm_cpu_model cpu (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd));

	// ==========
	// helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		cpu.read_reg(a, rv);
		chk(rv, exp);
	endtask : rchk

	// one-cycle pulse on hw standby, sw standby, watchdog reset
	task automatic stb(input logic [2:0] v);
		@(posedge clock_i);
		ctl <= v;
		@(posedge clock_i);
		ctl <= 3'h0;
	endtask : stb

	task automatic fire(input logic [5:0] v);
		@(posedge clock_i);
		ev <= v;
		@(posedge clock_i);
		ev <= 6'h00;
		#1;
	endtask : fire

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	// ==========
	// clock and hang guard
	initial begin
		clock_i = 1'h0;
		forever #12.5 clock_i = ~clock_i;
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		n_fail++;
		report_and_stop();
	end

	// ==========
	// main sequence
	initial begin
		{sys_rst_i, pin, fen, ctl, ev} = {1'h1, 1'h0, 1'h1, 3'h0, 6'h00};
		n_fail = 0;
		cmp_count = 0;
		repeat (12) @(posedge clock_i);
		sys_rst_i <= 1'h0;
		rchk(fcm_pkg::OFS_OP_CTRL, 8'h00);
		@(posedge clock_i);
		pin <= 1'h1;
		rchk(fcm_pkg::OFS_OP_CTRL, 8'h80);
		rchk(fcm_pkg::OFS_FAULT_STAT, 8'h00);
		rchk(fcm_pkg::OFS_WASH_SEL_LO, 8'h00);
		rchk(8'h3F, 8'h00);
		@(posedge clock_i);
		#1 chk(rdata, 8'h00);
		foreach (ROWS[i]) begin
			stb(3'h4);
			@(posedge clock_i);
			pin <= ROWS[i][19];
			if (ROWS[i][18]) cpu.write_reg(fcm_pkg::OFS_OP_CTRL, 8'h40);
			cpu.write_reg(fcm_pkg::OFS_OP_CTRL, ROWS[i][17:10]);
			rchk(fcm_pkg::OFS_OP_CTRL, ROWS[i][9:2]);
			chk({6'h00, mode}, {6'h00, ROWS[i][1:0]});
			chk({6'h00, wver, ever}, {6'h00, ROWS[i][4], ROWS[i][5]});
		end
		foreach (EVTS[i]) begin
			stb(3'h4);
			sel = 8'h01 << i;
			if (i % 2) cpu.enter_erase(sel);
			else cpu.enter_program();
			fire(EVTS[i][6:1]);
			chk({7'h00, prot}, {7'h00, EVTS[i][0]});
			chk({6'h00, wact, eact}, EVTS[i][0] ? 8'h00 : (i % 2 ? 8'h01 : 8'h02));
			chk(block_en, (i % 2 && !EVTS[i][0]) ? sel : 8'h00);
			chk({6'h00, mode}, 8'h03);
			rchk(fcm_pkg::OFS_FAULT_STAT, {EVTS[i][0], 7'h00});
		end
		stb(3'h2);
		rchk(fcm_pkg::OFS_OP_CTRL, 8'h80);
		stb(3'h1);
		rchk(fcm_pkg::OFS_FAULT_STAT, 8'h00);
		fire(6'h20);
		chk({7'h00, prot}, 8'h00);
		cpu.enter_program();
		cpu.leave_modes();
		rchk(fcm_pkg::OFS_OP_CTRL, 8'h80);
		chk({5'h00, wact, mode}, 8'h00);
		cpu.write_reg(fcm_pkg::OFS_OP_CTRL, 8'h40);
		@(posedge clock_i);
		pin <= 1'h0;
		rchk(fcm_pkg::OFS_OP_CTRL, 8'h00);
		@(posedge clock_i);
		pin <= 1'h1;
		rchk(fcm_pkg::OFS_OP_CTRL, 8'h80);
		@(posedge clock_i);
		fen <= 1'h0;
		cpu.write_reg(fcm_pkg::OFS_OP_CTRL, 8'h40);
		rchk(fcm_pkg::OFS_OP_CTRL, 8'h00);
		rchk(fcm_pkg::OFS_FAULT_STAT, 8'h00);
		@(posedge clock_i);
		fen <= 1'h1;
		rchk(fcm_pkg::OFS_OP_CTRL, 8'h80);
		// pin reset in mid-run clears a standing fault
		cpu.enter_program();
		fire(6'h01);
		chk({7'h00, prot}, 8'h01);
		@(posedge clock_i);
		sys_rst_i <= 1'h1;
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 1'h0;
		#1 chk({6'h00, wact, prot}, 8'h00);
		rchk(fcm_pkg::OFS_FAULT_STAT, 8'h00);
		rchk(fcm_pkg::OFS_OP_CTRL, 8'h80);
		report_and_stop();
	end
endmodule : fcm_ctrl_test
`default_nettype wire
